// >>> dv/test_register_field_access_policy.sv
// Self-checking bench for the register field access bank
`timescale 1ns/1ps
`include "rfa_params.svh"

module test_register_field_access_policy;
    import rfa_pkg::*;

    // ==========================================================
    // Bank setup: reg0 rw, reg1 one class per byte, reg2 context, reg3 stored
    function automatic logic [4*32*3-1:0] build_map();
        logic [4*32*3-1:0] m;
        rfa_cls_t          c;
        m = '0;
        for (int r = 0; r < 4; r++) begin
            for (int i = 0; i < 32; i++) begin
                case (r)
                    0: c = cls_rw;
                    2: c = cls_reserved_zero_context;
                    3: c = cls_reserved_zero_stored;
                    default: c = (i < 8) ? cls_read_zero_write_ignored :
                                 (i < 16) ? cls_read_as_one_field :
                                 (i < 24) ? cls_reserved_zero_hardwired :
                                            cls_reserved_zero_stored;
                endcase
                m[3*(32*r+i) +: 3] = c;
            end
        end
        return m;
    endfunction

    localparam logic [4*32*3-1:0] CLS = build_map();
    localparam logic [127:0]      RST = {32'h5a5a_a5a5, 32'h0000_00ff, 32'hffff_ffff, 32'h1234_5678};

    logic              ref_clk;
    logic              rst_b;
    logic              acc_valid;
    logic              acc_write;
    logic [7:0]        acc_addr;
    rfa_size_t         acc_size;
    logic [31:0]       acc_wdata;
    logic              acc_ready;
    logic              rsp_valid;
    logic              rsp_err;
    logic [31:0]       rsp_rdata;
    logic              ind_valid;
    logic [5:0]        ind_idx;
    logic [31:0]       ind_wdata;
    logic [3:0]        ctx_reserved_zero;
    logic [127:0]      fn_value;
    int                n_errors;
    int                checks;

    rfa_field_bank #(.NREG(4), .AW(8), .CLS_MAP(CLS), .RST_VAL(RST)) u_rfa_field_bank (
        .ref_clk(ref_clk), .rst_b(rst_b), .acc_valid(acc_valid), .acc_write(acc_write),
        .acc_addr(acc_addr), .acc_size(acc_size), .acc_wdata(acc_wdata),
        .acc_ready(acc_ready), .rsp_valid(rsp_valid), .rsp_err(rsp_err),
        .rsp_rdata(rsp_rdata), .ind_valid(ind_valid), .ind_idx(ind_idx),
        .ind_wdata(ind_wdata), .ctx_reserved_zero(ctx_reserved_zero),
        .fn_value(fn_value));

    always #25 ref_clk = ~ref_clk;

    // ==========================================================
    // Shared tasks
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic acc(input logic wr, input logic [7:0] a, input rfa_size_t s,
                       input logic [31:0] d, output logic [31:0] q, output logic e);
        @(posedge ref_clk);
        #1;
        acc_valid = 1'b1;
        acc_write = wr;
        acc_addr  = a;
        acc_size  = s;
        acc_wdata = d;
        @(posedge ref_clk);
        #1;
        acc_valid = 1'b0;
        chk("rsp_valid", {31'h0, rsp_valid}, 32'h1);
        chk("acc_ready", {31'h0, acc_ready}, 32'h1);
        q = rsp_rdata;
        e = rsp_err;
    endtask

    task automatic rd(input logic [7:0] a, input rfa_size_t s, input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        acc(1'b0, a, s, 32'h0, q, e);
        chk("rsp_err", {31'h0, e}, 32'h0);
        chk("rsp_rdata", q, exp);
    endtask

    task automatic wr(input logic [7:0] a, input rfa_size_t s, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        acc(1'b1, a, s, d, q, e);
        chk("rsp_err", {31'h0, e}, 32'h0);
    endtask

    task automatic bad(input logic [7:0] a, input rfa_size_t s);
        logic [31:0] q;
        logic        e;
        acc(1'b1, a, s, 32'hffff_ffff, q, e);
        chk("rsp_err refused", {31'h0, e}, 32'h1);
        chk("rsp_rdata refused", q, 32'h0);
    endtask

    task automatic ind(input logic [5:0] idx, input logic [31:0] d);
        @(posedge ref_clk);
        #1;
        ind_valid = 1'b1;
        ind_idx   = idx;
        ind_wdata = d;
        @(posedge ref_clk);
        #1;
        ind_valid = 1'b0;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset_values();
        rd(8'h00, sz_word, 32'h1234_5678);
        rd(8'h04, sz_word, 32'hff00_ff00);
        rd(8'h08, sz_word, 32'h0000_00ff);
        rd(8'h0c, sz_word, 32'h5a5a_a5a5);
    endtask

    task automatic t_classes();
        wr(8'h04, sz_word, 32'h1234_5678);
        rd(8'h04, sz_word, 32'h1200_ff00);
        chk("fn_value reg1", fn_value[63:32], 32'h0);
        wr(8'h04, sz_word, 32'h0000_ff00);
        rd(8'h04, sz_word, 32'h0000_ff00);
        wr(8'h04, sz_word, 32'h1200_ff00);
    endtask

    task automatic t_lanes();
        wr(8'h00, sz_word, 32'h0);
        wr(8'h01, sz_byte, 32'h0000_00ab);
        rd(8'h00, sz_word, 32'h0000_ab00);
        wr(8'h02, sz_half, 32'h0000_cdef);
        rd(8'h00, sz_word, 32'hcdef_ab00);
        rd(8'h02, sz_byte, 32'h0000_00ef);
        rd(8'h03, sz_byte, 32'h0000_00cd);
        rd(8'h00, sz_half, 32'h0000_ab00);
        wr(8'h00, sz_byte, 32'hffff_ff11);
        rd(8'h00, sz_word, 32'hcdef_ab11);
        rd(8'h00, sz_byte, 32'h0000_0011);
    endtask

    task automatic t_refused();
        bad(8'h01, sz_half);
        bad(8'h02, sz_word);
        bad(8'h00, rfa_size_t'(2'h3));
        bad(8'h10, sz_word);
        rd(8'h00, sz_word, 32'hcdef_ab11);
    endtask

    task automatic t_indirect();
        ind(6'h01, 32'hffff_ffff);
        rd(8'h04, sz_word, 32'h0000_ff00);
        ind(6'h03, 32'h1234_5678);
        rd(8'h0c, sz_word, 32'h0000_0000);
        ind(6'h00, 32'h0bad_f00d);
        rd(8'h00, sz_word, 32'h0bad_f00d);
        chk("fn_value reg0", fn_value[31:0], 32'h0bad_f00d);
    endtask

    task automatic t_context();
        ctx_reserved_zero = 4'h4;
        wr(8'h08, sz_word, 32'haaaa_5555);
        rd(8'h08, sz_word, 32'haaaa_5555);
        chk("fn_value reg2 reserved", fn_value[95:64], 32'h0);
        ctx_reserved_zero = 4'h0;
        #1;
        chk("fn_value reg2 live", fn_value[95:64], 32'haaaa_5555);
        ind(6'h02, 32'h3333_3333);
        rd(8'h08, sz_word, 32'h3333_3333);
        ctx_reserved_zero = 4'h4;
        ind(6'h02, 32'hffff_ffff);
        rd(8'h08, sz_word, 32'h0000_0000);
    endtask

    // Write then read on consecutive edges, then an idle cycle
    task automatic t_back_to_back();
        @(posedge ref_clk);
        #1;
        acc_valid = 1'b1;
        acc_write = 1'b1;
        acc_addr  = 8'h0c;
        acc_size  = sz_word;
        acc_wdata = 32'hc3c3_3c3c;
        @(posedge ref_clk);
        #1;
        acc_write = 1'b0;
        chk("rsp_err b2b write", {31'h0, rsp_err}, 32'h0);
        chk("rsp_rdata b2b write", rsp_rdata, 32'h0);
        @(posedge ref_clk);
        #1;
        acc_valid = 1'b0;
        chk("rsp_valid b2b read", {31'h0, rsp_valid}, 32'h1);
        chk("rsp_rdata b2b read", rsp_rdata, 32'hc3c3_3c3c);
        @(posedge ref_clk);
        #1;
        chk("rsp_valid idle", {31'h0, rsp_valid}, 32'h0);
        chk("rsp_rdata idle", rsp_rdata, 32'h0);
    endtask

    // Reset in mid-run brings stored bits back to their reset values
    task automatic t_mid_reset();
        rst_b = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        rst_b = 1'b1;
        rd(8'h0c, sz_word, 32'h5a5a_a5a5);
        rd(8'h04, sz_word, 32'hff00_ff00);
    endtask

    task automatic end_of_test();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        ref_clk   = 1'b0;
        rst_b     = 1'b0;
        acc_valid = 1'b0;
        acc_write = 1'b0;
        acc_addr  = 8'h00;
        acc_size  = sz_word;
        acc_wdata = 32'h0;
        ind_valid = 1'b0;
        ind_idx   = 6'h00;
        ind_wdata = 32'h0;
        ctx_reserved_zero = 4'h0;
        n_errors  = 0;
        checks    = 0;
        repeat (16) @(posedge ref_clk);
        #1;
        rst_b = 1'b1;
        t_reset_values();
        t_classes();
        t_lanes();
        t_refused();
        t_indirect();
        t_context();
        t_back_to_back();
        t_mid_reset();
        end_of_test();
    end

    initial begin
        #(4000 * 50);
        n_errors++;
        end_of_test();
    end

endmodule // test_register_field_access_policy

// >>> logic/rfa_field_bank.sv
// Register bank that applies per-bit field access classes
`timescale 1ns/1ps
`include "rfa_params.svh"

module rfa_field_bank #(
    parameter int                            NREG    = `RFA_NREG,
    parameter int                            AW      = `RFA_ADDR_W,
    // Class code per bit, bit i of register r at [3*(32*r+i) +: 3]
    parameter logic [NREG*32*`RFA_CLS_W-1:0] CLS_MAP = '0,
    parameter logic [NREG*32-1:0]            RST_VAL = '0
) (
    input  wire logic                      ref_clk,
    input  wire logic                      rst_b,
    input  wire logic                      acc_valid,
    input  wire logic                      acc_write,
    input  wire logic [AW-1:0]             acc_addr,
    input  wire rfa_pkg::rfa_size_t        acc_size,
    input  wire logic [`RFA_WORD_W-1:0]    acc_wdata,
    output logic                           acc_ready,
    output logic                           rsp_valid,
    output logic                           rsp_err,
    output logic      [`RFA_WORD_W-1:0]    rsp_rdata,
    input  wire logic                      ind_valid,
    input  wire logic [AW-3:0]             ind_idx,
    input  wire logic [`RFA_WORD_W-1:0]    ind_wdata,
    input  wire logic [NREG-1:0]           ctx_reserved_zero,
    output logic      [NREG*32-1:0]        fn_value
);
    import rfa_pkg::*;

    localparam int IW = AW - `RFA_IDX_LSB;

    // ==========================================================
    // Class masks built at elaboration
    // ==========================================================
    function automatic logic [NREG*32-1:0] cls_mask(input rfa_cls_t c);
        logic [NREG*32-1:0] m;
        m = '0;
        for (int i = 0; i < NREG*32; i++) begin
            m[i] = (CLS_MAP[`RFA_CLS_W*i +: `RFA_CLS_W] == c);
        end
        return m;
    endfunction

    localparam logic [NREG*32-1:0] M_RW   = cls_mask(cls_rw);
    // Zero class also serves plain reserved bits
    localparam logic [NREG*32-1:0] M_ZERO = cls_mask(cls_read_zero_write_ignored);
    localparam logic [NREG*32-1:0] M_ONE  = cls_mask(cls_read_as_one_field);
    localparam logic [NREG*32-1:0] M_HARD = cls_mask(cls_reserved_zero_hardwired);
    localparam logic [NREG*32-1:0] M_STOR = cls_mask(cls_reserved_zero_stored);
    localparam logic [NREG*32-1:0] M_CTX  = cls_mask(cls_reserved_zero_context);
    // Bits with storage behind them
    localparam logic [NREG*32-1:0] M_KEEP = M_RW | M_STOR | M_CTX;
    localparam logic [NREG*32-1:0] RST_KEPT = RST_VAL & M_KEEP;

    function automatic logic [31:0] slice(input logic [NREG*32-1:0] m,
                                          input logic [IW-1:0] r);
        return m[32*r +: 32];
    endfunction

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic [NREG-1:0][31:0] mem;
        logic                  rsp_valid;
        logic                  rsp_err;
        logic [31:0]           rdata;
        logic                  rsp_rd_word;
        logic [IW-1:0]         rsp_idx;
    } rfa_state_t;

    rfa_state_t st_r;
    rfa_state_t st_nxt;

    logic [IW-1:0] idx;
    logic          mapped;
    logic          ind_ok;
    logic [31:0]   word_view;
    logic [3:0]    be;
    logic [31:0]   wdata_al;
    logic [31:0]   rdata_rj;
    logic          misalign;
    logic [31:0]   wmask;
    logic [31:0]   ind_take;
    logic [NREG*32-1:0] ctx_bits;

    assign idx       = acc_addr[AW-1:`RFA_IDX_LSB];
    assign mapped    = (32'(idx) < 32'(NREG));
    assign ind_ok    = ind_valid && (32'(ind_idx) < 32'(NREG));
    assign acc_ready = 1'b1;

    always_comb begin
        ctx_bits = '0;
        for (int r = 0; r < NREG; r++) begin
            ctx_bits[32*r +: 32] = {32{ctx_reserved_zero[r]}};
        end
    end

    // Read view: stored bits, read-one bits forced high, all else zero
    always_comb begin
        word_view = 32'h0000_0000;
        if (mapped) begin
            word_view = (st_r.mem[idx] & slice(M_KEEP, idx))
                      | slice(M_ONE, idx);
        end
    end

    rfa_lane_map u_rfa_lane_map (
        .off      (acc_addr[1:0]),
        .size     (acc_size),
        .wdata    (acc_wdata),
        .word     (word_view),
        .be       (be),
        .wdata_al (wdata_al),
        .rdata_rj (rdata_rj),
        .misalign (misalign)
    );

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        st_nxt     = st_r;
        wmask      = 32'h0000_0000;
        ind_take   = 32'h0000_0000;
        st_nxt.rsp_valid   = acc_valid;
        st_nxt.rsp_err     = 1'b0;
        st_nxt.rdata       = 32'h0000_0000;
        st_nxt.rsp_rd_word = 1'b0;
        // Indirect update: plain bits load, reserved stored bits clear
        if (ind_ok) begin
            ind_take = slice(M_RW, ind_idx)
                     | (slice(M_CTX, ind_idx) & ~slice(ctx_bits, ind_idx));
            st_nxt.mem[ind_idx] = ind_wdata & ind_take;
        end
        if (acc_valid) begin
            st_nxt.rsp_idx = idx;
            st_nxt.rsp_err = !mapped || misalign;
            if (mapped && !misalign) begin
                if (acc_write) begin
                    // Only bits with storage take a direct write
                    wmask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}}
                          & slice(M_KEEP, idx);
                    st_nxt.mem[idx] = (st_nxt.mem[idx] & ~wmask)
                                    | (wdata_al & wmask);
                end else begin
                    st_nxt.rdata       = rdata_rj;
                    st_nxt.rsp_rd_word = (acc_size == sz_word);
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r.mem         <= RST_KEPT;
            st_r.rsp_valid   <= `RFA_RST_FLAG;
            st_r.rsp_err     <= `RFA_RST_FLAG;
            st_r.rdata       <= `RFA_RST_WORD;
            st_r.rsp_rd_word <= `RFA_RST_FLAG;
            st_r.rsp_idx     <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rsp_valid = st_r.rsp_valid;
    assign rsp_err   = st_r.rsp_err;
    assign rsp_rdata = st_r.rdata;
    // Reserved bits never reach the device's own logic
    assign fn_value  = st_r.mem & (M_RW | (M_CTX & ~ctx_bits));

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    logic [31:0] rsp_zero_m;
    logic [31:0] rsp_one_m;
    logic        first_cyc_r;
    logic [NREG*32-1:0] mem_flat;
    assign mem_flat   = st_r.mem;
    assign rsp_zero_m = slice(M_ZERO | M_HARD, st_r.rsp_idx);
    assign rsp_one_m  = slice(M_ONE, st_r.rsp_idx);

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            first_cyc_r <= 1'b1;
        end else begin
            first_cyc_r <= 1'b0;
        end
    end

    a_zero_reads_zero: assert property (
        rsp_valid && st_r.rsp_rd_word && !rsp_err |-> (rsp_rdata & rsp_zero_m) == 32'h0)
        else $error("read-zero bit returned one");

    a_one_reads_one: assert property (
        rsp_valid && st_r.rsp_rd_word && !rsp_err |-> (rsp_rdata & rsp_one_m) == rsp_one_m)
        else $error("read-one bit returned zero");

    a_nokeep_stays_zero: assert property (
        (st_r.mem & ~M_KEEP) == '0)
        else $error("bit without storage holds a value");

    a_ind_clears_rsv: assert property (
        ind_ok && !(acc_valid && acc_write) |=>
            (st_r.mem[$past(ind_idx)] & slice(M_STOR, $past(ind_idx))) == 32'h0)
        else $error("indirect update left reserved bit set");

    a_word_write_lands: assert property (
        acc_valid && acc_write && mapped && !misalign && acc_size == sz_word
            ##1 acc_valid && !acc_write && acc_addr == $past(acc_addr)
            && acc_size == sz_word && !ind_valid
        |=> rsp_rdata == ((($past(acc_wdata, 2) & slice(M_KEEP, st_r.rsp_idx))
                         | rsp_one_m))
        ) else $error("word write not read back");

    a_reset_value: assert property (
        first_cyc_r |-> st_r.mem == RST_KEPT)
        else $error("stored bits not at reset value");

    a_rsv_no_effect: assert property (
        (fn_value & (M_STOR | M_ZERO | M_ONE | M_HARD)) == '0)
        else $error("reserved bit reaches device logic");

    a_bad_access_err: assert property (
        acc_valid && (!mapped || misalign) |=> rsp_valid && rsp_err && rsp_rdata == 32'h0)
        else $error("bad access not flagged");

    a_byte_low_lane: assert property (
        acc_valid && !acc_write && acc_size == sz_byte && mapped
            && acc_addr[1:0] == 2'h0
        |=> rsp_rdata == (32'h0000_00ff & $past(word_view)))
        else $error("byte read used wrong lane");

    a_half_low_lanes: assert property (
        acc_valid && !acc_write && acc_size == sz_half && mapped
            && acc_addr[1:0] == 2'h0
        |=> rsp_rdata == (32'h0000_ffff & $past(word_view)))
        else $error("halfword read used wrong lanes");

    // Read view itself, before lane steering
    a_view_zero_bits: assert property (
        mapped |-> (word_view & slice(M_ZERO | M_HARD, idx)) == 32'h0)
        else $error("read view shows a zero-class bit set");

    a_view_one_bits: assert property (
        mapped |-> (word_view & slice(M_ONE, idx)) == slice(M_ONE, idx))
        else $error("read view shows a one-class bit clear");

    a_ind_loads_rw: assert property (
        ind_ok && !(acc_valid && acc_write) |=>
            (st_r.mem[$past(ind_idx)] & slice(M_RW, $past(ind_idx)))
            == ($past(ind_wdata) & slice(M_RW, $past(ind_idx))))
        else $error("indirect update did not load plain bits");

    // Context bits that were reserved when the update came must clear
    a_ind_clears_ctx: assert property (
        ind_ok && !(acc_valid && acc_write) |=>
            (st_r.mem[$past(ind_idx)]
             & slice(M_CTX & $past(ctx_bits), $past(ind_idx))) == 32'h0)
        else $error("indirect update left context bit set");

    // Refused writes leave every stored bit alone
    a_refused_no_write: assert property (
        acc_valid && acc_write && (!mapped || misalign) && !ind_ok
        |=> mem_flat == $past(mem_flat))
        else $error("refused write changed storage");

    a_write_rsp_zero: assert property (
        acc_valid && acc_write |=> rsp_valid && rsp_rdata == 32'h0)
        else $error("write answer carried data");

    a_rsp_one_cycle: assert property (
        !acc_valid |=> !rsp_valid)
        else $error("answer without an access");

    c_word_write: cover property (acc_valid && acc_write && acc_size == sz_word && mapped);
    c_byte_read:  cover property (acc_valid && !acc_write && acc_size == sz_byte && mapped);
    c_ind_write:  cover property (ind_ok && |ctx_reserved_zero);
    c_err_rsp:    cover property (rsp_valid && rsp_err);
    c_b2b_access: cover property (acc_valid && acc_write ##1 acc_valid && !acc_write);

endmodule // rfa_field_bank

// >>> logic/rfa_lane_map.sv
// Little-endian byte lane steering for one register access
`timescale 1ns/1ps
`include "rfa_params.svh"

module rfa_lane_map (
    input  wire logic [1:0]                off,
    input  wire rfa_pkg::rfa_size_t        size,
    input  wire logic [`RFA_WORD_W-1:0]    wdata,
    input  wire logic [`RFA_WORD_W-1:0]    word,
    output logic      [`RFA_LANES-1:0]     be,
    output logic      [`RFA_WORD_W-1:0]    wdata_al,
    output logic      [`RFA_WORD_W-1:0]    rdata_rj,
    output logic                           misalign
);
    import rfa_pkg::*;

    always_comb begin
        be       = 4'hf;
        wdata_al = wdata;
        rdata_rj = word;
        misalign = 1'b0;
        unique case (size)
            sz_byte: begin
                // Byte at a word address sits in the low lane, other offsets in lane off
                be       = 4'h1 << off;
                wdata_al = {4{wdata[7:0]}};
                rdata_rj = {24'h00_0000, word[8*off +: 8]};
            end
            sz_half: begin
                // Halfword at a word address sits in the low half
                be       = off[1] ? 4'hc : 4'h3;
                wdata_al = {2{wdata[15:0]}};
                rdata_rj = {16'h0000, (off[1] ? word[31:16] : word[15:0])};
                misalign = off[0];
            end
            sz_word: begin
                misalign = |off;
            end
            default: begin
                misalign = 1'b1;
            end
        endcase
    end

endmodule // rfa_lane_map

// >>> logic/rfa_params.svh
// Shared constants for the register field access block
`ifndef RFA_PARAMS_SVH
`define RFA_PARAMS_SVH

// Data word and byte lanes
`define RFA_WORD_W      32
`define RFA_LANES       4
`define RFA_LANE_W      8
// Field class attribute: bits per register bit
`define RFA_CLS_W       3
// Word index starts at this byte address bit
`define RFA_IDX_LSB     2
// Default bank geometry
`define RFA_NREG        4
`define RFA_ADDR_W      8
// Reset values
`define RFA_RST_WORD    32'h0000_0000
`define RFA_RST_FLAG    1'b0
// Cycles from a taken access to its answer
`define RFA_RSP_LAT     1

`endif

// >>> logic/rfa_pkg.sv
// Types for the register field access block
package rfa_pkg;

    // Access class of one register bit
    typedef enum logic [2:0] {
        cls_rw                      = 3'h0,
        cls_read_zero_write_ignored = 3'h1,
        cls_read_as_one_field       = 3'h2,
        cls_reserved_zero_hardwired = 3'h3,
        cls_reserved_zero_stored    = 3'h4,
        cls_reserved_zero_context   = 3'h5
    } rfa_cls_t;

    // Access width
    typedef enum logic [1:0] {
        sz_byte = 2'h0,
        sz_half = 2'h1,
        sz_word = 2'h2
    } rfa_size_t;

endpackage
